/* core/vwire_cmp_consts.svh */
`ifndef VWIRE_CMP_CONSTS_SVH
`define VWIRE_CMP_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_WIRE_SRC 8'h90
`define OFS_CMP_CTRL 8'h94
`define OFS_CMP_SLEEP 8'h98
`define OFS_WIRE_GROUP 8'ha0
`define OFS_HW_STATUS 8'ha4
// ****************************************
// Field positions and resets
// ****************************************
`define WIRE_SRC_RST 3'h7
`define BIT_WIRE_SOURCE_BIT_ZERO 0
`define BIT_WIRE_SOURCE_BIT_ONE 1
`define BIT_SRC2 2
`define BIT_CMP0_EN 0
`define BIT_CMP0_LOCK 2
`define BIT_CMP_RSV3 3
`define BIT_CMP1_EN 4
`define BIT_SLEEP0 0
`define BIT_SLEEP1 1
`define WIRE_SRC_MSB 2
`define BIT_ST_STRAP 2
`define BIT_ST_SMI 1
`define BIT_ST_SCI 0
`endif

/* core/vwire_cmp_pkg.sv */
package vwire_cmp_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
  typedef struct packed {
    logic cmp0_en;
    logic cmp1_en;
    logic cmp0_sleep;
    logic cmp1_sleep;
    logic cfg_lock;
  } cmp_cfg_type;
endpackage : vwire_cmp_pkg

/* core/vwire_comparator_config_regs.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "vwire_cmp_consts.svh"
module vwire_comparator_config_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire vwire_cmp_pkg::reg_req_type req,
  output logic [31:0] rdata,
  input wire logic comparator0_strap_pin,
  input wire logic mailbox_host_smi_request,
  input wire logic controller_sci_request,
  output logic [1:0] smi_sci_wire_group_reg,
  output vwire_cmp_pkg::cmp_cfg_type cmp_cfg
);
  import vwire_cmp_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Left out of reset so the strap has settled by the end of reset
  // Both flops run while reset is held
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic strap_s;
  logic smi_s;
  logic sci_s;

  always_ff @(posedge clk) begin
    if (clk_en) begin
      pin_meta_r <= {comparator0_strap_pin, mailbox_host_smi_request, controller_sci_request};
    end
  end

  // Only this stage may read the first flop
  always_ff @(posedge clk) begin
    if (clk_en) begin
      pin_sync_r <= pin_meta_r;
    end
  end

  assign strap_s = pin_sync_r[`BIT_ST_STRAP];
  assign smi_s = pin_sync_r[`BIT_ST_SMI];
  assign sci_s = pin_sync_r[`BIT_ST_SCI];

  // ****************************************
  // Register bus decode
  // ****************************************
  // The slave never stalls; a strobe seen with clk_en low is lost
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic wr_hit(input reg_req_type r, input logic [7:0] ofs);
    wr_hit = r.wr && hit(r.addr, ofs);
  endfunction : wr_hit

  logic wr_src;
  logic wr_ctl;
  logic wr_slp;
  logic wr_grp;

  assign wr_src = wr_hit(req, `OFS_WIRE_SRC);
  assign wr_ctl = wr_hit(req, `OFS_CMP_CTRL);
  assign wr_slp = wr_hit(req, `OFS_CMP_SLEEP);
  assign wr_grp = wr_hit(req, `OFS_WIRE_GROUP);

  // ****************************************
  // Wire source mask
  // ****************************************
  // Mask bit 2 has no hardware source behind it
  logic [2:0] wire_source_mask_r;
  logic [2:0] wire_source_mask_nxt;

  always_comb begin
    wire_source_mask_nxt = wire_source_mask_r;
    if (wr_src) begin
      // Top bit stored as written; firmware must keep it at one
      wire_source_mask_nxt = req.wdata[`WIRE_SRC_MSB:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wire_source_mask_r <= `WIRE_SRC_RST;
    end else if (clk_en) begin
      wire_source_mask_r <= wire_source_mask_nxt;
    end
  end

  // ****************************************
  // SMI and SCI source bits
  // ****************************************
  // Firmware write wins for one cycle; an unmasked source retakes the bit next cycle
  logic [1:0] grp_nxt;

  always_comb begin
    grp_nxt = smi_sci_wire_group_reg;
    if (!wire_source_mask_r[`BIT_WIRE_SOURCE_BIT_ONE]) begin
      grp_nxt[`BIT_WIRE_SOURCE_BIT_ONE] = smi_s;
    end
    if (!wire_source_mask_r[`BIT_WIRE_SOURCE_BIT_ZERO]) begin
      grp_nxt[`BIT_WIRE_SOURCE_BIT_ZERO] = sci_s;
    end
    if (wr_grp) begin
      grp_nxt[`BIT_WIRE_SOURCE_BIT_ONE] = req.wdata[`BIT_WIRE_SOURCE_BIT_ONE];
      grp_nxt[`BIT_WIRE_SOURCE_BIT_ZERO] = req.wdata[`BIT_WIRE_SOURCE_BIT_ZERO];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smi_sci_wire_group_reg <= 2'h0;
    end else if (clk_en) begin
      smi_sci_wire_group_reg <= grp_nxt;
    end
  end

  // ****************************************
  // Strap capture
  // ****************************************
  // Reset may load only constants, so the strap is taken one cycle later
  // A high strap locks comparator 0 before software runs
  logic strap_pend_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_pend_r <= 1'b1;
    end else if (clk_en) begin
      strap_pend_r <= 1'b0;
    end
  end

  // ****************************************
  // Comparator 0 and lock
  // ****************************************
  // A control write in the capture cycle loses its lock and cmp0 bits; software waits one cycle
  logic lock_r;
  logic lock_nxt;
  logic cmp0_en_r;
  logic cmp0_en_nxt;

  always_comb begin
    lock_nxt = lock_r;
    cmp0_en_nxt = cmp0_en_r;
    if (strap_pend_r) begin
      lock_nxt = strap_s;
      cmp0_en_nxt = strap_s;
    end else if (wr_ctl && !lock_r) begin
      lock_nxt = req.wdata[`BIT_CMP0_LOCK];
      cmp0_en_nxt = req.wdata[`BIT_CMP0_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_r <= 1'b0;
    end else if (clk_en) begin
      lock_r <= lock_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp0_en_r <= 1'b0;
    end else if (clk_en) begin
      cmp0_en_r <= cmp0_en_nxt;
    end
  end

  // ****************************************
  // Comparator 1 and spare bit
  // ****************************************
  // Comparator 1 has no lock
  logic cmp1_en_r;
  logic cmp1_en_nxt;
  logic rsv3_r;
  logic rsv3_nxt;

  always_comb begin
    cmp1_en_nxt = cmp1_en_r;
    rsv3_nxt = rsv3_r;
    if (wr_ctl) begin
      cmp1_en_nxt = req.wdata[`BIT_CMP1_EN];
      // Spare bit stays writable even while locked
      rsv3_nxt = req.wdata[`BIT_CMP_RSV3];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp1_en_r <= 1'b0;
    end else if (clk_en) begin
      cmp1_en_r <= cmp1_en_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsv3_r <= 1'b0;
    end else if (clk_en) begin
      rsv3_r <= rsv3_nxt;
    end
  end

  // ****************************************
  // Deep sleep enables
  // ****************************************
  // Sleep 0 follows the comparator 0 lock, sleep 1 never locks
  logic slp0_r;
  logic slp0_nxt;
  logic slp1_r;
  logic slp1_nxt;

  always_comb begin
    slp0_nxt = slp0_r;
    slp1_nxt = slp1_r;
    if (wr_slp) begin
      slp1_nxt = req.wdata[`BIT_SLEEP1];
      if (!lock_r) begin
        slp0_nxt = req.wdata[`BIT_SLEEP0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slp0_r <= 1'b0;
    end else if (clk_en) begin
      slp0_r <= slp0_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slp1_r <= 1'b0;
    end else if (clk_en) begin
      slp1_r <= slp1_nxt;
    end
  end

  // ****************************************
  // Configuration outputs
  // ****************************************
  // One cycle behind the registers to keep every output on a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp_cfg <= '0;
    end else if (clk_en) begin
      cmp_cfg.cmp0_en <= cmp0_en_r;
      cmp_cfg.cmp1_en <= cmp1_en_r;
      cmp_cfg.cmp0_sleep <= slp0_r;
      cmp_cfg.cmp1_sleep <= slp1_r;
      cmp_cfg.cfg_lock <= lock_r;
    end
  end

  // ****************************************
  // Read words
  // ****************************************
  // Reserved control bit 1 always reads zero
  function automatic logic [31:0] ctrl_word(
    input logic c1,
    input logic sp,
    input logic lk,
    input logic c0
  );
    ctrl_word = 32'h0;
    ctrl_word[`BIT_CMP1_EN] = c1;
    ctrl_word[`BIT_CMP_RSV3] = sp;
    ctrl_word[`BIT_CMP0_LOCK] = lk;
    ctrl_word[`BIT_CMP0_EN] = c0;
  endfunction : ctrl_word

  function automatic logic [31:0] pair_word(input logic hi, input logic lo);
    pair_word = 32'h0;
    pair_word[`BIT_SLEEP1] = hi;
    pair_word[`BIT_SLEEP0] = lo;
  endfunction : pair_word

  function automatic logic [31:0] status_word(input logic st, input logic sm, input logic sc);
    status_word = 32'h0;
    status_word[`BIT_ST_STRAP] = st;
    status_word[`BIT_ST_SMI] = sm;
    status_word[`BIT_ST_SCI] = sc;
  endfunction : status_word

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped offsets and reserved bits read as zero; spare control bit 3 reads back as written
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0;
    case (req.addr)
      `OFS_WIRE_SRC: begin
        rd_nxt[`WIRE_SRC_MSB:0] = wire_source_mask_r;
      end
      `OFS_CMP_CTRL: begin
        rd_nxt = ctrl_word(cmp1_en_r, rsv3_r, lock_r, cmp0_en_r);
      end
      `OFS_CMP_SLEEP: begin
        rd_nxt = pair_word(slp1_r, slp0_r);
      end
      `OFS_WIRE_GROUP: begin
        rd_nxt = pair_word(smi_sci_wire_group_reg[`BIT_WIRE_SOURCE_BIT_ONE],
                           smi_sci_wire_group_reg[`BIT_WIRE_SOURCE_BIT_ZERO]);
      end
      `OFS_HW_STATUS: begin
        rd_nxt = status_word(strap_s, smi_s, sci_s);
      end
      default: begin
        rd_nxt = 32'h0;
      end
    endcase
  end

  // Read data stands one cycle, then returns to zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= 32'h0;
    end else if (clk_en) begin
      if (req.rd) begin
        rdata <= rd_nxt;
      end else begin
        rdata <= 32'h0;
      end
    end
  end
endmodule : vwire_comparator_config_regs

/* tb/vwire_cfg_checker.sv */
`timescale 1ns/10ps
// ****
// Port checker
// ****
module vwire_cfg_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire vwire_cmp_pkg::reg_req_type req,
  input wire logic [31:0] rdata,
  input wire vwire_cmp_pkg::cmp_cfg_type cmp_cfg
);
  import vwire_cmp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_LOCK_HOLD: assert property (cmp_cfg.cfg_lock |=> cmp_cfg.cfg_lock)
    else $error("lock fell");
  AST_CMP0_FROZEN: assert property (cmp_cfg.cfg_lock && $past(cmp_cfg.cfg_lock)
    |-> $stable(cmp_cfg.cmp0_en)) else $error("cmp0 moved while locked");
  AST_SLEEP0_FROZEN: assert property (cmp_cfg.cfg_lock && $past(cmp_cfg.cfg_lock)
    |-> $stable(cmp_cfg.cmp0_sleep)) else $error("sleep0 moved while locked");
  AST_CMP1_WR: assert property (req.wr && req.addr == 8'h94
    |=> ##1 cmp_cfg.cmp1_en == $past(req.wdata[4], 2)) else $error("cmp1 not written");
  // Lock may rise one cycle before cmp_cfg shows it, so skip writes right after a write
  AST_CMP0_WR: assert property (req.wr && req.addr == 8'h94 && !cmp_cfg.cfg_lock
    && !$past(req.wr) |=> ##1 cmp_cfg.cmp0_en == $past(req.wdata[0], 2))
    else $error("cmp0 not written");
  AST_SLEEP1_WR: assert property (req.wr && req.addr == 8'h98
    |=> ##1 cmp_cfg.cmp1_sleep == $past(req.wdata[1], 2)) else $error("sleep1 not written");
  AST_SLEEP_RD: assert property (req.rd && req.addr == 8'h98 |=> rdata[31:2] == 30'h0)
    else $error("sleep high bits set");
  AST_RESET_CLEAR: assert property ($fell(sys_rst) |-> cmp_cfg == 5'h0)
    else $error("cfg not cleared");
endmodule : vwire_cfg_checker
bind vwire_comparator_config_regs vwire_cfg_checker vwire_cfg_checker_i (.clk, .sys_rst,
  .req, .rdata, .cmp_cfg);

/* tb/test_vwire_comparator_config_regs.sv */
`timescale 1ns/10ps
// ****
// Bench
// ****
module test_vwire_comparator_config_regs;
  import vwire_cmp_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, smi = 1'h0, sci = 1'h0, strap = 1'h0, ce = 1'h1;
  reg_req_type req = '0;
  logic [31:0] rdata;
  logic [1:0] grp;
  cmp_cfg_type cfg;
  int err_count = 0, total_checks = 0, cyc = 0;
  // Strap starts low: lock and cmp0 start cleared
  vwire_comparator_config_regs vwire_comparator_config_regs_i (.clk(clk), .sys_rst(sys_rst),
    .clk_en(ce), .req(req), .rdata(rdata), .comparator0_strap_pin(strap),
    .mailbox_host_smi_request(smi), .controller_sci_request(sci),
    .smi_sci_wire_group_reg(grp), .cmp_cfg(cfg));
  initial forever #4 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'h1, 1'h0};
    @(posedge clk);
    req.wr <= 1'h0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    req <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge clk);
    req.rd <= 1'h0;
    #1 chk("rdata", e, rdata);
  endtask : rd
  task automatic reset_vals;
    rd(8'h90, 32'h7);
    rd(8'h94, 32'h0);
    rd(8'h98, 32'h0);
    rd(8'h9c, 32'h0);
    rd(8'ha4, 32'h0);
  endtask : reset_vals
  task automatic lock_seq;
    wr(8'h98, 32'h3);
    rd(8'h98, 32'h3);
    wr(8'h94, 32'h11);
    rd(8'h94, 32'h11);
    wr(8'h94, 32'h15);
    wr(8'h94, 32'h0);
    rd(8'h94, 32'h5);
    wr(8'h98, 32'h0);
    rd(8'h98, 32'h1);
    chk("cmp_cfg", 32'h15, {27'h0, cfg});
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    rd(8'h94, 32'h0);
  endtask : lock_seq
  task automatic strap_seq;
    @(posedge clk);
    strap <= 1'h1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    rd(8'h94, 32'h5);
    rd(8'ha4, 32'h4);
    wr(8'h94, 32'h0);
    rd(8'h94, 32'h5);
  endtask : strap_seq
  task automatic wire_seq;
    wr(8'ha0, 32'h3);
    rd(8'ha0, 32'h3);
    @(posedge clk);
    {smi, sci} <= 2'h3;
    wr(8'ha0, 32'h0);
    // Sources pass a two-flop synchroniser first
    repeat (5) @(posedge clk);
    #1 chk("group", 32'h0, {30'h0, grp});
    wr(8'h90, 32'h5);
    repeat (5) @(posedge clk);
    #1 chk("group", 32'h2, {30'h0, grp});
    wr(8'h90, 32'h6);
    wr(8'ha0, 32'h0);
    repeat (5) @(posedge clk);
    #1 chk("group", 32'h1, {30'h0, grp});
    // Clock enable low freezes the synchroniser and the group bits
    @(posedge clk);
    ce <= 1'h0;
    sci <= 1'h0;
    repeat (6) @(posedge clk);
    #1 chk("group", 32'h1, {30'h0, grp});
    @(posedge clk);
    ce <= 1'h1;
    repeat (5) @(posedge clk);
    #1 chk("group", 32'h0, {30'h0, grp});
  endtask : wire_seq
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    reset_vals();
    lock_seq();
    strap_seq();
    wire_seq();
    tally_and_finish();
  end
endmodule : test_vwire_comparator_config_regs
